// ---- design/iep_pkg.sv ----
package iep_pkg;

    // special function register addresses
    localparam logic [7:0] ADDR_BASIC_PRIO = 8'hB8;
    localparam logic [7:0] ADDR_EXT_EN_ONE = 8'hE6;
    localparam logic [7:0] ADDR_EXT_EN_TWO = 8'hE7;
    localparam logic [7:0] ADDR_EXT_PRIO_ONE = 8'hF6;

    // reset values
    localparam logic [7:0] RST_BASIC_PRIO = 8'h00;
    localparam logic [7:0] RST_EXT_EN_ONE = 8'h00;
    localparam logic [7:0] RST_EXT_EN_TWO = 8'h00;
    localparam logic [7:0] RST_EXT_PRIO_ONE = 8'h00;

    // basic priority: upper two bits unused, read as ones
    localparam logic [7:0] BASIC_PRIO_RD_ONES = 8'hC0;
    localparam logic [7:0] BASIC_PRIO_WR_MASK = 8'h3F;
    // second enable: bit 6 reserved, reads zero
    localparam logic [7:0] EXT_EN_TWO_WR_MASK = 8'hBF;
    localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

    // flag positions inside peripheral control bytes
    localparam int CMP_RISE_FLAG_BIT = 5;
    localparam int CMP_FALL_FLAG_BIT = 4;
    localparam int OSC_VALID_FLAG_BIT = 7;
    localparam int TIMER3_OVF_FLAG_BIT = 7;
    localparam int TWOWIRE_FLAG_BIT = 3;

    // source vector indices, lower index wins at equal level
    localparam int NUM_SRC = 22;
    localparam int SRC_IDX_W = 5;
    localparam int SRC_SERIAL_PERIPH = 6;
    localparam int SRC_TWOWIRE = 7;
    localparam int SRC_CONV_WINDOW = 8;
    localparam int SRC_COUNTER_ARRAY = 9;
    localparam int SRC_CMP0_FALL = 10;
    localparam int SRC_CMP0_RISE = 11;
    localparam int SRC_CMP1_FALL = 12;
    localparam int SRC_CMP1_RISE = 13;
    localparam int SRC_TIMER3 = 14;
    localparam int SRC_CONV_DONE = 15;
    localparam int SRC_EXT_PIN4 = 16;
    localparam int SRC_UNUSED = 20;
    localparam int SRC_CRYSTAL_VALID = 21;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } iep_sfr_req_t;

    typedef struct packed {
        logic valid;
        logic high;
        logic [4:0] idx;
    } iep_irq_t;

endpackage : iep_pkg

// ---- design/iep_arb.sv ----
`timescale 1ns/100ps
module iep_arb #(
    parameter int N = 22,
    parameter int IW = 5
) (
    // candidates
    input wire logic [N-1:0] req,
    input wire logic [N-1:0] high,
    // core service state
    input wire logic in_service_low,
    input wire logic in_service_high,
    // winner
    output logic valid,
    output logic win_high,
    output logic [IW-1:0] idx
);

    logic [N-1:0] req_hi;
    logic [N-1:0] req_lo;
    logic [N-1:0] pick;
    logic any_hi;
    logic any_lo;
    logic take_hi;
    logic take_lo;

    assign req_hi = req & high;
    assign req_lo = req & ~high;
    assign any_hi = |req_hi;
    assign any_lo = |req_lo;
    // high preempts low, nothing preempts high
    assign take_hi = any_hi && !in_service_high; // [R13]
    assign take_lo = !take_hi && any_lo && !in_service_low && !in_service_high; // [R13]
    assign pick = take_hi ? req_hi : req_lo;
    assign valid = take_hi || take_lo;
    assign win_high = take_hi;

    // lowest index wins within one level
    always_comb begin
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pick[i]) begin
                idx = IW'(i); // [R14]
            end
        end
    end

endmodule : iep_arb

// ---- design/iep_ctrl.sv ----
`timescale 1ns/100ps
// How it works
// [R1] basic priority bits 7-6 read ones, ignore writes
// [R2] basic priority ranks six classic sources
// [R3] first enable masks eight extended sources
// [R4] comparator enables use own edge flag
// [R5] two-wire, counter array, serial peripheral gating
// [R6] second enable masks crystal, pins, converter, timer3
// [R7] second enable bit 6 reads zero
// [R8] pin 4-7 enables gate own pins
// [R9] crystal and timer3 flags from control bit 7
// [R10] first extended priority ranks eight sources
// [R11] cleared enable blocks pending flag
// [R12] global enable overrides every mask
// [R13] high preempts low, high never preempted
// [R14] equal level falls back to index order
// [R15] requests sampled and decoded every cycle
// [R16] reset clears all enables and priorities; here only the four registers, not basic_en, ext_prio_two or global_irq_en
module iep_ctrl #(
    parameter int COUNTER_ARRAY_FLAGS = 6
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // special function register port
    input iep_pkg::iep_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    // enables and priority held outside
    input wire logic global_irq_en,
    input wire logic [5:0] basic_en,
    input wire logic [7:0] ext_prio_two,
    // classic pending flags, vector order
    input wire logic [5:0] classic_flags,
    // peripheral flags
    input wire logic [3:0] serial_periph_flags,
    input wire logic [7:0] twowire_ctrl,
    input wire logic conv_window_flag,
    input wire logic [COUNTER_ARRAY_FLAGS-1:0] counter_array_flags,
    input wire logic [7:0] cmp0_ctrl,
    input wire logic [7:0] cmp1_ctrl,
    input wire logic [7:0] timer3_ctrl,
    input wire logic conv_done_flag,
    input wire logic [3:0] ext_pin_flags,
    input wire logic [7:0] ext_osc_ctrl,
    // core service state
    input wire logic in_service_low,
    input wire logic in_service_high,
    // request to core
    output iep_pkg::iep_irq_t irq,
    // register views
    output logic [7:0] ext_en_one,
    output logic [7:0] ext_en_two,
    output logic [7:0] basic_prio,
    output logic [7:0] ext_prio_one
);

    logic [7:0] basic_prio_r;
    logic [7:0] ext_en_one_r;
    logic [7:0] ext_en_two_r;
    logic [7:0] ext_prio_one_r;
    logic [7:0] sfr_rdata_r;
    logic [7:0] sfr_rdata_nxt;
    iep_pkg::iep_irq_t irq_r;
    iep_pkg::iep_irq_t irq_nxt;

    wire logic hit_basic_prio = sfr_req.addr == iep_pkg::ADDR_BASIC_PRIO;
    wire logic hit_ext_en_one = sfr_req.addr == iep_pkg::ADDR_EXT_EN_ONE;
    wire logic hit_ext_en_two = sfr_req.addr == iep_pkg::ADDR_EXT_EN_TWO;
    wire logic hit_ext_prio_one = sfr_req.addr == iep_pkg::ADDR_EXT_PRIO_ONE;

    wire logic wr_basic_prio = sfr_req.wr && hit_basic_prio;
    wire logic wr_ext_en_one = sfr_req.wr && hit_ext_en_one;
    wire logic wr_ext_en_two = sfr_req.wr && hit_ext_en_two;
    wire logic wr_ext_prio_one = sfr_req.wr && hit_ext_prio_one;

    // stored images keep unused bits at zero
    wire logic [7:0] basic_prio_wval = sfr_req.wdata & iep_pkg::BASIC_PRIO_WR_MASK; // [R1]
    wire logic [7:0] ext_en_two_wval = sfr_req.wdata & iep_pkg::EXT_EN_TWO_WR_MASK; // [R7]

    // read views
    wire logic [7:0] basic_prio_view = basic_prio_r | iep_pkg::BASIC_PRIO_RD_ONES; // [R1]
    wire logic [7:0] ext_en_two_view = ext_en_two_r & iep_pkg::EXT_EN_TWO_WR_MASK; // [R7]

    assign sfr_rdata_nxt = hit_basic_prio ? basic_prio_view :
                           hit_ext_en_one ? ext_en_one_r :
                           hit_ext_en_two ? ext_en_two_view :
                           hit_ext_prio_one ? ext_prio_one_r :
                           iep_pkg::UNMAPPED_RDATA;

    // classic and extended pending flags, vector order
    logic [iep_pkg::NUM_SRC-1:0] pend;
    always_comb begin
        pend = '0;
        pend[5:0] = classic_flags;
        pend[iep_pkg::SRC_SERIAL_PERIPH] = |serial_periph_flags; // [R5]
        pend[iep_pkg::SRC_TWOWIRE] = twowire_ctrl[iep_pkg::TWOWIRE_FLAG_BIT]; // [R5]
        pend[iep_pkg::SRC_CONV_WINDOW] = conv_window_flag;
        pend[iep_pkg::SRC_COUNTER_ARRAY] = |counter_array_flags; // [R5]
        pend[iep_pkg::SRC_CMP0_FALL] = cmp0_ctrl[iep_pkg::CMP_FALL_FLAG_BIT]; // [R4]
        pend[iep_pkg::SRC_CMP0_RISE] = cmp0_ctrl[iep_pkg::CMP_RISE_FLAG_BIT]; // [R4]
        pend[iep_pkg::SRC_CMP1_FALL] = cmp1_ctrl[iep_pkg::CMP_FALL_FLAG_BIT]; // [R4]
        pend[iep_pkg::SRC_CMP1_RISE] = cmp1_ctrl[iep_pkg::CMP_RISE_FLAG_BIT]; // [R4]
        pend[iep_pkg::SRC_TIMER3] = timer3_ctrl[iep_pkg::TIMER3_OVF_FLAG_BIT]; // [R9]
        pend[iep_pkg::SRC_CONV_DONE] = conv_done_flag;
        pend[iep_pkg::SRC_EXT_PIN4 +: 4] = ext_pin_flags; // [R8]
        pend[iep_pkg::SRC_CRYSTAL_VALID] = ext_osc_ctrl[iep_pkg::OSC_VALID_FLAG_BIT]; // [R9]
    end

    // enable registers concatenated in vector order, bit i of the first enable at index 6+i
    wire logic [iep_pkg::NUM_SRC-1:0] src_en = {ext_en_two_view, ext_en_one_r, basic_en}; // [R3] [R6]
    wire logic [iep_pkg::NUM_SRC-1:0] src_high =
        {ext_prio_two, ext_prio_one_r, basic_prio_r[5:0]}; // [R2] [R10]
    // unused slot can never request even if its enable were set
    wire logic [iep_pkg::NUM_SRC-1:0] src_req =
        (pend & src_en & ~(iep_pkg::NUM_SRC'(1) << iep_pkg::SRC_UNUSED))
        & {iep_pkg::NUM_SRC{global_irq_en}}; // [R11] [R12]

    logic arb_valid;
    logic arb_high;
    logic [iep_pkg::SRC_IDX_W-1:0] arb_idx;

    iep_arb #(
        .N(iep_pkg::NUM_SRC),
        .IW(iep_pkg::SRC_IDX_W)
    ) u_arb (
        .req(src_req),
        .high(src_high),
        .in_service_low(in_service_low),
        .in_service_high(in_service_high),
        .valid(arb_valid),
        .win_high(arb_high),
        .idx(arb_idx)
    );

    assign irq_nxt = '{valid: arb_valid, high: arb_high, idx: arb_idx};

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            basic_prio_r <= iep_pkg::RST_BASIC_PRIO; // [R16]
            ext_en_one_r <= iep_pkg::RST_EXT_EN_ONE; // [R16]
            ext_en_two_r <= iep_pkg::RST_EXT_EN_TWO; // [R16]
            ext_prio_one_r <= iep_pkg::RST_EXT_PRIO_ONE; // [R16]
        end else begin
            if (wr_basic_prio) begin
                basic_prio_r <= basic_prio_wval; // [R2]
            end
            if (wr_ext_en_one) begin
                ext_en_one_r <= sfr_req.wdata; // [R3]
            end
            if (wr_ext_en_two) begin
                ext_en_two_r <= ext_en_two_wval; // [R6]
            end
            if (wr_ext_prio_one) begin
                ext_prio_one_r <= sfr_req.wdata; // [R10]
            end
        end
    end

    // read data and request both registered; one cycle latency each
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sfr_rdata_r <= 8'h00;
            irq_r <= '0;
        end else begin
            if (sfr_req.rd) begin
                sfr_rdata_r <= sfr_rdata_nxt;
            end
            irq_r <= irq_nxt; // [R15]
        end
    end

    assign sfr_rdata = sfr_rdata_r;
    assign irq = irq_r;
    assign basic_prio = basic_prio_view;
    assign ext_en_one = ext_en_one_r;
    assign ext_en_two = ext_en_two_view;
    assign ext_prio_one = ext_prio_one_r;

endmodule : iep_ctrl

// ---- verif/iep_periph_model.sv ----
`timescale 1ns/100ps
module iep_periph_model #(
    parameter int CA_W = 6
) (
    // pending sources, vector order
    input wire logic [21:0] pend,
    // peripheral flag views
    output logic [5:0] classic_flags,
    output logic [3:0] serial_periph_flags,
    output logic [7:0] twowire_ctrl,
    output logic conv_window_flag,
    output logic [CA_W-1:0] counter_array_flags,
    output logic [7:0] cmp0_ctrl,
    output logic [7:0] cmp1_ctrl,
    output logic [7:0] timer3_ctrl,
    output logic conv_done_flag,
    output logic [3:0] ext_pin_flags,
    output logic [7:0] ext_osc_ctrl
);
    // unrelated control bits held high so a wrong bit pick shows up
    assign classic_flags = pend[5:0];
    assign serial_periph_flags = {pend[6], 3'h0};
    assign twowire_ctrl = {4'hF, pend[7], 3'h7};
    assign conv_window_flag = pend[8];
    assign counter_array_flags = {pend[9], {(CA_W-1){1'h0}}};
    assign cmp0_ctrl = {2'h3, pend[11], pend[10], 4'hF};
    assign cmp1_ctrl = {2'h3, pend[13], pend[12], 4'hF};
    assign timer3_ctrl = {pend[14], 7'h7F};
    assign conv_done_flag = pend[15];
    assign ext_pin_flags = pend[19:16];
    assign ext_osc_ctrl = {pend[21], 7'h7F};
endmodule : iep_periph_model

// ---- verif/iep_ctrl_assertions.sv ----
`timescale 1ns/100ps
module iep_ctrl_assertions (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // observed ports
    input iep_pkg::iep_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic global_irq_en,
    input wire logic conv_done_flag,
    input wire logic in_service_high,
    input iep_pkg::iep_irq_t irq,
    input wire logic [7:0] ext_en_one,
    input wire logic [7:0] ext_en_two,
    input wire logic [7:0] basic_prio,
    input wire logic [7:0] ext_prio_one
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    prio_ones_a: assert property (basic_prio[7:6] == 2'h3) else $error("prio top bits");
    prio_write_a: assert property (sfr_req.wr && sfr_req.addr == 8'hB8 |=>
        basic_prio == {2'h3, $past(sfr_req.wdata[5:0])}) else $error("prio write");
    en_one_write_a: assert property (sfr_req.wr && sfr_req.addr == 8'hE6 |=>
        ext_en_one == $past(sfr_req.wdata)) else $error("enable write");
    en_one_read_a: assert property (sfr_req.rd && sfr_req.addr == 8'hE6 |=>
        sfr_rdata == $past(ext_en_one)) else $error("enable read");
    en_two_write_a: assert property (sfr_req.wr && sfr_req.addr == 8'hE7 |=>
        ext_en_two == ($past(sfr_req.wdata) & 8'hBF)) else $error("enable two write");
    prio_one_write_a: assert property (sfr_req.wr && sfr_req.addr == 8'hF6 |=>
        ext_prio_one == $past(sfr_req.wdata)) else $error("ext prio write");
    reserved_zero_a: assert property (ext_en_two[6] == 1'h0) else $error("reserved bit");
    done_mask_a: assert property (irq.valid && irq.idx == 5'h0F |->
        $past(ext_en_two[1] && conv_done_flag)) else $error("masked source");
    global_off_a: assert property (!global_irq_en |=> !irq.valid) else $error("global");
    high_hold_a: assert property (in_service_high |=> !irq.valid) else $error("preempt");
    reset_clear_a: assert property ($fell(reset) |-> ext_en_one == 8'h00 &&
        ext_prio_one == 8'h00 && ext_en_two == 8'h00) else $error("reset value");
endmodule : iep_ctrl_assertions
bind iep_ctrl iep_ctrl_assertions i_chk (.clk_sys(clk_sys), .reset(reset),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .global_irq_en(global_irq_en),
    .conv_done_flag(conv_done_flag), .in_service_high(in_service_high), .irq(irq),
    .ext_en_one(ext_en_one), .ext_en_two(ext_en_two), .basic_prio(basic_prio),
    .ext_prio_one(ext_prio_one));

// ---- verif/interrupt_enable_priority_regs_bench.sv ----
`timescale 1ns/100ps
module interrupt_enable_priority_regs_bench;
    logic clk_sys = 1'h0;
    logic reset = 1'h1;
    iep_pkg::iep_sfr_req_t sfr_req = '0;
    logic [7:0] sfr_rdata;
    logic glb = 1'h0, svc_lo = 1'h0, svc_hi = 1'h0;
    logic [7:0] prio_two = 8'h00;
    logic [5:0] basic_en = 6'h00;
    logic [21:0] pend = 22'h0;
    logic [5:0] cf, cnt;
    logic [3:0] spf, epf;
    logic [7:0] twc, c0c, c1c, t3c, osc;
    logic cwf, cdf;
    iep_pkg::iep_irq_t irq;
    int failures = 0, total_checks = 0;
    initial forever #50 clk_sys = ~clk_sys;
    iep_periph_model i_peri (.pend(pend), .classic_flags(cf), .serial_periph_flags(spf),
        .twowire_ctrl(twc), .conv_window_flag(cwf), .counter_array_flags(cnt),
        .cmp0_ctrl(c0c), .cmp1_ctrl(c1c), .timer3_ctrl(t3c), .conv_done_flag(cdf),
        .ext_pin_flags(epf), .ext_osc_ctrl(osc));
    iep_ctrl i_dut (.clk_sys(clk_sys), .reset(reset), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .global_irq_en(glb), .basic_en(basic_en), .ext_prio_two(prio_two), .classic_flags(cf),
        .serial_periph_flags(spf), .twowire_ctrl(twc), .conv_window_flag(cwf),
        .counter_array_flags(cnt), .cmp0_ctrl(c0c), .cmp1_ctrl(c1c), .timer3_ctrl(t3c),
        .conv_done_flag(cdf), .ext_pin_flags(epf), .ext_osc_ctrl(osc),
        .in_service_low(svc_lo), .in_service_high(svc_hi), .irq(irq), .ext_en_one(),
        .ext_en_two(), .basic_prio(), .ext_prio_one());
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_irq(input logic v, input logic h, input logic [4:0] i);
        @(negedge clk_sys);
        @(negedge clk_sys);
        total_checks++;
        if (irq !== {v, h, i}) begin
            failures++;
            $display("[ERR] %0t irq got %h exp %h", $time, irq, {v, h, i});
        end
    endtask : chk_irq
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        sfr_req = '{addr: a, wr: 1'h1, rd: 1'h0, wdata: d};
        @(negedge clk_sys);
        sfr_req.wr = 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        sfr_req = '{addr: a, wr: 1'h0, rd: 1'h1, wdata: 8'h00};
        @(negedge clk_sys);
        sfr_req.rd = 1'h0;
        chk_reg(sfr_rdata, exp);
    endtask : rd
    initial begin
        #500000;
        failures++;
        close_out();
    end
    initial begin
        repeat (6) @(negedge clk_sys);
        reset = 1'h0;
        rd(8'hB8, 8'hC0);
        rd(8'hE6, 8'h00);
        rd(8'hE7, 8'h00);
        rd(8'hF6, 8'h00);
        wr(8'hB8, 8'h1E);
        rd(8'hB8, 8'hDE);
        // software keeps the reserved enable bit at zero
        wr(8'hE7, 8'hBF);
        rd(8'hE7, 8'hBF);
        wr(8'hF6, 8'h5A);
        rd(8'hF6, 8'h5A);
        rd(8'h00, 8'h00);
        wr(8'hB8, 8'h00);
        wr(8'hF6, 8'h00);
        wr(8'hE6, 8'hFF);
        rd(8'hE6, 8'hFF);
        basic_en = 6'h3F;
        glb = 1'h1;
        // one source at a time, index order, vector 20 never forwarded
        for (int s = 0; s < 22; s++) begin
            pend = 22'h1 << s;
            chk_irq(s != 20, 1'h0, (s == 20) ? 5'h00 : 5'(s));
        end
        pend = 22'h000021;
        chk_irq(1'h1, 1'h0, 5'h00);
        wr(8'hB8, 8'h20);
        chk_irq(1'h1, 1'h1, 5'h05);
        // level decides before index, second priority byte included
        prio_two = 8'h02;
        pend = 22'h008001;
        chk_irq(1'h1, 1'h1, 5'h0F);
        prio_two = 8'h00;
        pend = 22'h002040;
        chk_irq(1'h1, 1'h0, 5'h06);
        wr(8'hF6, 8'h80);
        chk_irq(1'h1, 1'h1, 5'h0D);
        svc_lo = 1'h1;
        chk_irq(1'h1, 1'h1, 5'h0D);
        // blocked low candidate still shows its index with valid low
        pend = 22'h000040;
        chk_irq(1'h0, 1'h0, 5'h06);
        pend = 22'h002000;
        svc_hi = 1'h1;
        chk_irq(1'h0, 1'h0, 5'h00);
        {svc_lo, svc_hi} = 2'h0;
        glb = 1'h0;
        chk_irq(1'h0, 1'h0, 5'h00);
        glb = 1'h1;
        pend = 22'h008000;
        wr(8'hE7, 8'hBD);
        chk_irq(1'h0, 1'h0, 5'h00);
        wr(8'hE6, 8'h7F);
        pend = 22'h002000;
        chk_irq(1'h0, 1'h0, 5'h00);
        // mid-run reset: programmed bits must all drop
        pend = 22'h000021;
        reset = 1'h1;
        chk_irq(1'h0, 1'h0, 5'h00);
        reset = 1'h0;
        rd(8'hB8, 8'hC0);
        rd(8'hE6, 8'h00);
        rd(8'hE7, 8'h00);
        rd(8'hF6, 8'h00);
        chk_irq(1'h1, 1'h0, 5'h00);
        close_out();
    end
endmodule : interrupt_enable_priority_regs_bench
